// ### core/prx_core.sv
// proximity sensor core: i2c slave, power sequencing, measurement burst
`timescale 1ns/1ps
`include "prx_map.svh"

module prx_core #(
   parameter int READY_CYC = (`PRX_READY_NS / 1000) * `PRX_CLK_MHZ
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              srst,
   // i2c pins
   input  wire logic              scl_in,
   input  wire logic              sda_in,
   output wire logic              sda_out,
   output wire logic              sda_oe,
   // optical front end
   input  wire logic [7:0]        pd_sample,
   output prx_pkg::prx_emit_s     emit
);
   prx_pkg::prx_state_s s_q, s_d;

   function automatic logic [7:0] rd_byte(input prx_pkg::prx_state_s s, input logic [7:0] a);
      case (a)
         `PRX_REG_ENABLE: rd_byte = s.en;
         `PRX_REG_PCFG0:  rd_byte = s.pcfg0;
         `PRX_REG_PCFG1:  rd_byte = s.pcfg1;
         `PRX_REG_CFG3:   rd_byte = s.cfg3;
         `PRX_REG_OFS_LO: rd_byte = s.ofs_lo;
         `PRX_REG_OFS_HI: rd_byte = s.ofs_hi;
         `PRX_REG_STATUS: rd_byte = {4'h0, s.sai_hold, s.pst, s.valid};
         `PRX_REG_RES_LO: rd_byte = s.result[7:0];
         `PRX_REG_RES_HI: rd_byte = {2'h0, s.hi_shadow};
         default:         rd_byte = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic        scl_r, scl_f, st, sp, wr, done;
      logic [7:0]  wd, rb;
      logic [11:0] plen;
      logic [16:0] gacc;
      logic [18:0] sub;
      s_d   = s_q;
      scl_r = scl_in & ~s_q.scl_p;
      scl_f = ~scl_in & s_q.scl_p;
      st    = scl_in & s_q.scl_p & s_q.sda_p & ~sda_in;
      sp    = scl_in & s_q.scl_p & ~s_q.sda_p & sda_in;
      wr    = 1'b0;
      done  = 1'b0;
      wd    = {s_q.sh[6:0], sda_in};
      rb    = rd_byte(s_q, s_q.ptr);
      plen  = 12'(`PRX_PLEN_CYC) << s_q.pcfg0[7:6];
      gacc  = 17'(s_q.acc) << s_q.pcfg1[7:6];
      sub   = {5'h00, s_q.acc} - 19'd0;
      s_d.scl_p = scl_in;
      s_d.sda_p = sda_in;
      // power-on ready window, addresses are not acknowledged before it
      if (!s_q.ready) begin
         s_d.rdy_cnt = s_q.rdy_cnt + 16'h0001;
         if (s_q.rdy_cnt == 16'(READY_CYC - 1)) s_d.ready = 1'b1;
      end
      // i2c slave
      case (s_q.ist)
         prx_pkg::IC_IDLE: ;
         prx_pkg::IC_ADDR: if (scl_r) begin
            s_d.sh   = wd;
            s_d.bcnt = s_q.bcnt + 3'h1;
            if (s_q.bcnt == 3'h7) begin
               if (s_q.ready && wd[7:1] == `PRX_CHIP_ADDR) begin
                  s_d.rw  = wd[0];
                  s_d.drv = 1'b0;
                  s_d.ist = prx_pkg::IC_ACK;
               end else begin
                  s_d.ist = prx_pkg::IC_IDLE;
               end
            end
         end
         prx_pkg::IC_ACK: if (scl_f) begin
            if (!s_q.drv) begin
               s_d.drv    = 1'b1;
               s_d.sda_oe = 1'b1;
            end else if (s_q.rw) begin
               s_d.drv    = 1'b0;
               s_d.sh     = rb;
               s_d.sda_oe = ~rb[7];
               s_d.ptr    = s_q.ptr + 8'h01;
               s_d.bcnt   = 3'h0;
               s_d.ist    = prx_pkg::IC_RBYTE;
               if (s_q.ptr == `PRX_REG_RES_LO) s_d.hi_shadow = s_q.result[13:8];
            end else begin
               s_d.drv    = 1'b0;
               s_d.sda_oe = 1'b0;
               s_d.bcnt   = 3'h0;
               s_d.ist    = prx_pkg::IC_WBYTE;
            end
         end
         prx_pkg::IC_WBYTE: if (scl_r) begin
            s_d.sh   = wd;
            s_d.bcnt = s_q.bcnt + 3'h1;
            if (s_q.bcnt == 3'h7) begin
               s_d.ist = prx_pkg::IC_ACK;
               if (s_q.first) begin
                  s_d.ptr   = wd;
                  s_d.first = 1'b0;
               end else begin
                  wr        = 1'b1;
                  s_d.ptr   = s_q.ptr + 8'h01;
               end
            end
         end
         prx_pkg::IC_RBYTE: begin
            if (scl_f) begin
               s_d.sh     = {s_q.sh[6:0], 1'b0};
               s_d.sda_oe = ~s_q.sh[6];
            end
            if (scl_r) begin
               s_d.bcnt = s_q.bcnt + 3'h1;
               if (s_q.bcnt == 3'h7) s_d.ist = prx_pkg::IC_MACK;
            end
         end
         prx_pkg::IC_MACK: begin
            if (scl_f) s_d.sda_oe = 1'b0;
            if (scl_r) begin
               // master ack continues the burst, nack waits for stop
               s_d.ist = sda_in ? prx_pkg::IC_IDLE : prx_pkg::IC_ACK;
               s_d.drv = 1'b1;
            end
         end
         default: s_d.ist = prx_pkg::IC_IDLE;
      endcase
      if (st) begin
         s_d.ist    = prx_pkg::IC_ADDR;
         s_d.bcnt   = 3'h0;
         s_d.first  = 1'b1;
         s_d.sda_oe = 1'b0;
      end
      if (sp) begin
         // pointer left untouched so the next read resumes here
         s_d.ist    = prx_pkg::IC_IDLE;
         s_d.sda_oe = 1'b0;
      end
      // register writes
      if (wr) begin
         case (s_q.ptr)
            `PRX_REG_ENABLE: begin
               s_d.en       = wd;
               s_d.sai_hold = 1'b0;
            end
            `PRX_REG_PCFG0:  s_d.pcfg0  = wd;
            `PRX_REG_PCFG1:  s_d.pcfg1  = wd;
            `PRX_REG_CFG3:   s_d.cfg3   = wd;
            `PRX_REG_OFS_LO: s_d.ofs_lo = wd;
            `PRX_REG_OFS_HI: s_d.ofs_hi = wd;
            default: ;
         endcase
      end
      // offset is 9-bit two's complement; positive lowers the result
      sub = {2'b00, gacc} - {{11{s_q.ofs_hi[0]}}, s_q.ofs_lo};
      // power and measurement sequencer; counters move in wake and active, and a pon clear
      // only stops them once the i2c slave is idle; oscillator approximated by the system clock
      case (s_q.pst)
         prx_pkg::PW_SLEEP: if (s_q.en[`PRX_EN_PON] && !s_q.sai_hold) begin
            if (s_q.en[`PRX_EN_PEN]) begin
               s_d.pst = prx_pkg::PW_WAKE;
               s_d.tmr = 12'(`PRX_WAKE_CYC - 1);
            end else begin
               s_d.pst = prx_pkg::PW_IDLE;
            end
         end
         prx_pkg::PW_WAKE: begin
            s_d.tmr = s_q.tmr - 12'h001;
            if (s_q.tmr == 12'h000) begin
               s_d.pst  = prx_pkg::PW_ACTIVE;
               s_d.seg  = 2'd0;
               s_d.tmr  = 12'(7 * plen - 1);
               s_d.pidx = 6'h00;
               s_d.acc  = 14'h0000;
            end
         end
         prx_pkg::PW_IDLE: if (s_q.en[`PRX_EN_PEN]) begin
            s_d.pst  = prx_pkg::PW_ACTIVE;
            s_d.seg  = 2'd0;
            s_d.tmr  = 12'(7 * plen - 1);
            s_d.pidx = 6'h00;
            s_d.acc  = 14'h0000;
         end
         prx_pkg::PW_ACTIVE: begin
            s_d.tmr = s_q.tmr - 12'h001;
            if (s_q.tmr == 12'h000) begin
               case (s_q.seg)
                  2'd0: begin
                     s_d.seg = 2'd1;
                     s_d.tmr = 12'(2 * plen - 1);
                  end
                  2'd1: begin
                     s_d.acc = s_q.acc + 14'(pd_sample);
                     s_d.seg = 2'd2;
                     s_d.tmr = 12'(`PRX_GAP_CYC - 1);
                  end
                  2'd2: begin
                     s_d.pidx = s_q.pidx + 6'h01;
                     s_d.seg  = (s_q.pidx == s_q.pcfg0[5:0]) ? 2'd3 : 2'd1;
                     s_d.tmr  = (s_q.pidx == s_q.pcfg0[5:0]) ?
                                12'(`PRX_POST_CYC - 1) : 12'(2 * plen - 1);
                  end
                  default: done = 1'b1;
               endcase
            end
         end
         default: s_d.pst = prx_pkg::PW_SLEEP;
      endcase
      if (done) begin
         // whole word at once; high byte reads come from the shadow
         s_d.result = sub[18] ? 14'h0000 : (|sub[17:14] ? 14'h3fff : sub[13:0]);
         s_d.valid  = 1'b1;
         if (s_q.cfg3[`PRX_CFG3_SAI]) begin
            s_d.pst      = prx_pkg::PW_SLEEP;
            s_d.sai_hold = 1'b1;
         end else begin
            s_d.pst = prx_pkg::PW_IDLE;
         end
      end
      if (!s_q.en[`PRX_EN_PON] && s_q.ist == prx_pkg::IC_IDLE)
         s_d.pst = prx_pkg::PW_SLEEP;
      if (srst) begin
         s_d       = '0;
         s_d.pst   = prx_pkg::PW_SLEEP;
         s_d.ist   = prx_pkg::IC_IDLE;
         s_d.scl_p = 1'b1;
         s_d.sda_p = 1'b1;
         s_d.en    = `PRX_ENABLE_RST;
         s_d.pcfg0 = `PRX_PCFG0_RST;
         s_d.pcfg1 = `PRX_PCFG1_RST;
         s_d.cfg3  = `PRX_CFG3_RST;
      end
   end

   always_ff @(posedge clk) begin
      s_q <= s_d;
   end

   assign sda_out       = 1'b0;
   assign sda_oe        = s_q.sda_oe;
   // one driver for the whole struct, members never assigned apart
   assign emit          = '{on:      (s_q.pst == prx_pkg::PW_ACTIVE) && (s_q.seg == 2'd1),
                            drive:   s_q.pcfg1[4:0],
                            gain:    s_q.pcfg1[7:6],
                            osc_run: s_q.en[`PRX_EN_PON]};

   ////////////////////////////////////////////////////////////////////////////
   logic [17:0] act_cnt_q;
   logic [17:0] act_exp;
   logic [11:0] plen_a;
   assign plen_a  = 12'(`PRX_PLEN_CYC) << s_q.pcfg0[7:6];
   assign act_exp = 18'(7 * plen_a + (s_q.pcfg0[5:0] + 1) * (2 * plen_a + `PRX_GAP_CYC)
                    + `PRX_POST_CYC);
   always_ff @(posedge clk) begin
      act_cnt_q <= (srst || s_q.pst != prx_pkg::PW_ACTIVE) ? 18'h00000 : act_cnt_q + 18'h00001;
   end

   sequence s_wake_req;
      s_q.pst == prx_pkg::PW_SLEEP && s_q.en[`PRX_EN_PON] && s_q.en[`PRX_EN_PEN] && !s_q.sai_hold;
   endsequence
   sequence s_measure_done;
      s_q.pst == prx_pkg::PW_ACTIVE && s_q.seg == 2'd3 && s_q.tmr == 12'h000;
   endsequence

   // wake length kept in a counter, a delay range this long is too costly
   logic [10:0] wake_cnt_q;
   always_ff @(posedge clk) begin
      wake_cnt_q <= (srst || s_q.pst != prx_pkg::PW_WAKE) ? 11'h000 : wake_cnt_q + 11'h001;
   end
   property p_wake;
      @(posedge clk) disable iff (srst) s_wake_req |=> s_q.pst == prx_pkg::PW_WAKE;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not started");
   property p_wake_len;
      @(posedge clk) disable iff (srst)
         s_q.pst == prx_pkg::PW_WAKE |-> wake_cnt_q < 11'(`PRX_WAKE_CYC);
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake too slow");
   property p_wake_end;
      @(posedge clk) disable iff (srst)
         s_q.pst == prx_pkg::PW_WAKE && wake_cnt_q == 11'(`PRX_WAKE_CYC - 1)
         && s_q.en[`PRX_EN_PON] |=> s_q.pst == prx_pkg::PW_ACTIVE;
   endproperty
   a_wake_end: assert property (p_wake_end) else $error("wake did not end active");
   property p_active_len;
      @(posedge clk) disable iff (srst) s_measure_done |-> act_cnt_q + 18'h00001 == act_exp;
   endproperty
   a_active_len: assert property (p_active_len) else $error("active length wrong");
   property p_idle;
      @(posedge clk) disable iff (srst)
         s_q.pst == prx_pkg::PW_SLEEP && s_q.en[`PRX_EN_PON] && !s_q.en[`PRX_EN_PEN]
         && !s_q.sai_hold |=> s_q.pst == prx_pkg::PW_IDLE;
   endproperty
   a_idle: assert property (p_idle) else $error("idle not entered");
   property p_sleep;
      @(posedge clk) disable iff (srst)
         !s_q.en[`PRX_EN_PON] && s_q.ist == prx_pkg::IC_IDLE |=> s_q.pst == prx_pkg::PW_SLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not entered");
   property p_sai;
      @(posedge clk) disable iff (srst)
         s_measure_done ##0 s_q.cfg3[`PRX_CFG3_SAI] ##0 s_q.en[`PRX_EN_PON]
         |=> s_q.pst == prx_pkg::PW_SLEEP && s_q.en[`PRX_EN_PON];
   endproperty
   a_sai: assert property (p_sai) else $error("pon cleared on sai sleep");
   property p_result_atomic;
      @(posedge clk) disable iff (srst) !s_measure_done |=> $stable(s_q.result);
   endproperty
   a_result_atomic: assert property (p_result_atomic) else $error("result torn");
   property p_ack;
      @(posedge clk) disable iff (srst)
         s_q.ist == prx_pkg::IC_ACK && !s_q.drv && !scl_in && s_q.scl_p |=> sda_oe [*1];
   endproperty
   a_ack: assert property (p_ack) else $error("ack not driven");
   property p_ptr_inc;
      @(posedge clk) disable iff (srst)
         s_q.ist == prx_pkg::IC_WBYTE && s_q.bcnt == 3'h7 && scl_in && !s_q.scl_p && !s_q.first
         |=> s_q.ptr == $past(s_q.ptr) + 8'h01;
   endproperty
   a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");
   property p_not_ready;
      @(posedge clk) disable iff (srst) !s_q.ready |-> !sda_oe;
   endproperty
   a_not_ready: assert property (p_not_ready) else $error("ack before ready");
   property p_ptr_hold;
      @(posedge clk) disable iff (srst) s_q.ist == prx_pkg::IC_IDLE |=> $stable(s_q.ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer lost");
endmodule

// ### inc/prx_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef PRX_MAP_SVH
`define PRX_MAP_SVH
`define PRX_CHIP_ADDR    7'h39
`define PRX_REG_ENABLE   8'h80
`define PRX_REG_PCFG0    8'h8e
`define PRX_REG_PCFG1    8'h8f
`define PRX_REG_STATUS   8'h9b
`define PRX_REG_RES_LO   8'h9c
`define PRX_REG_RES_HI   8'h9d
`define PRX_REG_CFG3     8'hab
`define PRX_REG_OFS_LO   8'hc0
`define PRX_REG_OFS_HI   8'hc1
`define PRX_EN_PON       0
`define PRX_EN_PEN       2
`define PRX_CFG3_SAI     4
`define PRX_ENABLE_RST   8'h00
`define PRX_PCFG0_RST    8'h8f
`define PRX_PCFG1_RST    8'h60
`define PRX_CFG3_RST     8'h04
`define PRX_CLK_MHZ      10
`define PRX_WAKE_NS      100000
`define PRX_READY_NS     1500000
`define PRX_GAP_NS       22000
`define PRX_POST_NS      78750
`define PRX_PLEN_BASE_NS 4000
`define PRX_WAKE_CYC     ((`PRX_WAKE_NS * `PRX_CLK_MHZ) / 1000)
`define PRX_GAP_CYC      ((`PRX_GAP_NS * `PRX_CLK_MHZ + 999) / 1000)
`define PRX_POST_CYC     ((`PRX_POST_NS * `PRX_CLK_MHZ + 999) / 1000)
`define PRX_PLEN_CYC     ((`PRX_PLEN_BASE_NS * `PRX_CLK_MHZ + 999) / 1000)
`endif

// ### inc/prx_pkg.sv
// types shared by the proximity core
package prx_pkg;
   typedef enum logic [1:0] {
      PW_SLEEP  = 2'b00,
      PW_WAKE   = 2'b01,
      PW_ACTIVE = 2'b11,
      PW_IDLE   = 2'b10
   } prx_pwr_e;

   typedef enum logic [2:0] {
      IC_IDLE  = 3'b000,
      IC_ADDR  = 3'b001,
      IC_ACK   = 3'b011,
      IC_WBYTE = 3'b010,
      IC_RBYTE = 3'b110,
      IC_MACK  = 3'b111
   } prx_i2c_e;

   typedef struct packed {
      logic       on;
      logic [4:0] drive;
      logic [1:0] gain;
      logic       osc_run;
   } prx_emit_s;

   typedef struct packed {
      prx_pwr_e    pst;
      logic [1:0]  seg;
      logic [11:0] tmr;
      logic [5:0]  pidx;
      logic [13:0] acc;
      logic [13:0] result;
      logic [5:0]  hi_shadow;
      logic        valid;
      logic        sai_hold;
      logic [7:0]  en;
      logic [7:0]  pcfg0;
      logic [7:0]  pcfg1;
      logic [7:0]  cfg3;
      logic [7:0]  ofs_lo;
      logic [7:0]  ofs_hi;
      prx_i2c_e    ist;
      logic        scl_p;
      logic        sda_p;
      logic [2:0]  bcnt;
      logic [7:0]  sh;
      logic [7:0]  ptr;
      logic        rw;
      logic        first;
      logic        drv;
      logic        sda_oe;
      logic [15:0] rdy_cnt;
      logic        ready;
   } prx_state_s;
endpackage

// ### test/prx_host.sv
// host i2c master model driving the proximity core pins
`timescale 1ns/1ps
`include "prx_map.svh"
module prx_host (
   // clock
   input  wire logic clk,
   // i2c wire
   output wire logic scl_in,
   output wire logic sda_in,
   input  wire logic sda_out,
   input  wire logic sda_oe
);
   logic scl_q;
   logic sda_q;
   // pulled-up open drain: a released wire reads 1
   assign scl_in = scl_q;
   assign sda_in = sda_q & ~(sda_oe & ~sda_out);
   initial begin
      scl_q = 1'b1;
      sda_q = 1'b1;
   end
////////////////////////////////////////////////////////////////////////////////
   // 4 cycles a phase keeps above the 3-cycle minimum
   task automatic drv(input logic s, input logic d);
      @(posedge clk);
      scl_q <= s;
      sda_q <= d;
      repeat (3) @(posedge clk);
   endtask
   task automatic start();
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      drv(1'b1, 1'b0);
      drv(1'b0, 1'b0);
   endtask
   task automatic stop();
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b1);
   endtask
   task automatic bit_io(input logic b, output logic r);
      drv(1'b0, b);
      drv(1'b1, b);
      #1 r = sda_in;
   endtask
   task automatic put(input logic [7:0] v, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(v[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic get(input logic last, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         v[i] = r;
      end
      bit_io(last, r);
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] rg, input logic [7:0] d[$], output logic ok);
      logic a;
      start();
      put({`PRX_CHIP_ADDR, 1'b0}, ok);
      put(rg, a);
      ok &= a;
      foreach (d[i]) begin
         put(d[i], a);
         ok &= a;
      end
      stop();
   endtask
   task automatic rd(input logic wreg, input logic [7:0] rg, input int n,
                     output logic [7:0] q[$], output logic ok);
      logic       a;
      logic [7:0] v;
      q = {};
      ok = 1'b1;
      start();
      if (wreg) begin
         put({`PRX_CHIP_ADDR, 1'b0}, a);
         put(rg, ok);
         ok &= a;
         start();
      end
      // no register byte: the kept pointer serves
      put({`PRX_CHIP_ADDR, 1'b1}, a);
      ok &= a;
      for (int i = 0; i < n; i++) begin
         get(i == n - 1, v);
         q.push_back(v);
      end
      stop();
   endtask
endmodule

// ### test/prx_core_test.sv
// self-checking bench for the proximity core
`timescale 1ns/1ps
`include "prx_map.svh"
module prx_core_test;
   localparam int READY = 200;
   localparam int L     = `PRX_PLEN_CYC;
   localparam int WAKE  = `PRX_WAKE_CYC;
   // two pulses, shortest length code
   localparam int ACT   = 7 * L + 2 * (2 * L + `PRX_GAP_CYC) + `PRX_POST_CYC;
   logic               clk;
   logic               srst;
   logic               scl_in;
   logic               sda_in;
   logic               sda_out;
   logic               sda_oe;
   logic [7:0]         pd_sample;
   prx_pkg::prx_emit_s emit;
   int                 miscompares;
   int                 total_checks;
   int                 cycles;
   logic               ok;
   logic [7:0]         q[$];

   prx_core #(.READY_CYC(READY)) prx_core_i (
      .clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe(sda_oe), .pd_sample(pd_sample), .emit(emit));
   prx_host prx_host_i (
      .clk(clk), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

   initial clk = 1'b0;
   always #50 clk = ~clk;
////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr1(input logic [7:0] rg, input logic [7:0] d);
      prx_host_i.wr(rg, {d}, ok);
      chk_bit(ok, 1'b1);
   endtask
   task automatic rd1(input logic [7:0] rg, output logic [7:0] v);
      prx_host_i.rd(1'b1, rg, 1, q, ok);
      chk_bit(ok, 1'b1);
      v = q[0];
   endtask
////////////////////////////////////////////////////////////////////////////////
   task automatic t_addr();
      logic a;
      prx_host_i.start();
      prx_host_i.put({`PRX_CHIP_ADDR, 1'b0}, a);
      prx_host_i.stop();
      chk_bit(a, 1'b0);
      repeat (READY) @(posedge clk);
      prx_host_i.start();
      prx_host_i.put({7'h38, 1'b0}, a);
      prx_host_i.stop();
      chk_bit(a, 1'b0);
   endtask
   task automatic t_reset_vals();
      logic [7:0] rg[4] = '{`PRX_REG_ENABLE, `PRX_REG_PCFG0, `PRX_REG_PCFG1, `PRX_REG_CFG3};
      logic [7:0] rv[4] = '{`PRX_ENABLE_RST, `PRX_PCFG0_RST, `PRX_PCFG1_RST, `PRX_CFG3_RST};
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         rd1(rg[i], v);
         chk_val({8'h00, v}, {8'h00, rv[i]});
      end
   endtask
   task automatic t_pointer();
      logic [7:0] v;
      prx_host_i.wr(`PRX_REG_PCFG0, {8'h01, 8'h43}, ok);
      chk_bit(ok, 1'b1);
      rd1(`PRX_REG_PCFG0, v);
      chk_val({8'h00, v}, 16'h0001);
      prx_host_i.rd(1'b0, 8'h00, 2, q, ok);
      chk_bit(ok, 1'b1);
      chk_val({q[0], q[1]}, 16'h4300);
      wr1(8'h90, 8'haa);
      rd1(8'h90, v);
      chk_val({8'h00, v}, 16'h0000);
      chk_val({9'h000, emit.gain, emit.drive}, 16'h0023);
   endtask
   task automatic t_measure(input logic [8:0] ofs, input logic [13:0] exp);
      int n;
      wr1(`PRX_REG_ENABLE, 8'h00);
      prx_host_i.wr(`PRX_REG_OFS_LO, {ofs[7:0], 8'(ofs[8])}, ok);
      chk_bit(ok, 1'b1);
      wr1(`PRX_REG_ENABLE, 8'h05);
      chk_bit(emit.osc_run, 1'b1);
      n = 0;
      while (emit.on !== 1'b1 && n < WAKE + ACT) begin
         @(negedge clk);
         n++;
      end
      chk_bit(emit.on, 1'b1);
      repeat (WAKE + ACT) @(posedge clk);
      prx_host_i.rd(1'b1, `PRX_REG_RES_LO, 2, q, ok);
      chk_val({2'b00, q[1][5:0], q[0]}, {2'b00, exp});
   endtask
   task automatic t_power();
      logic [7:0] v;
      wr1(`PRX_REG_ENABLE, 8'h01);
      // a burst still running from the last scenario must end first
      repeat (ACT + 100) @(posedge clk);
      rd1(`PRX_REG_STATUS, v);
      chk_val({14'h0000, v[2:1]}, 16'h0002);
      wr1(`PRX_REG_ENABLE, 8'h00);
      @(negedge clk);
      chk_bit(emit.osc_run, 1'b0);
      chk_bit(emit.on, 1'b0);
      wr1(`PRX_REG_CFG3, 8'h14);
      wr1(`PRX_REG_ENABLE, 8'h05);
      repeat (WAKE + ACT + 100) @(posedge clk);
      rd1(`PRX_REG_ENABLE, v);
      chk_val({8'h00, v}, 16'h0005);
      rd1(`PRX_REG_STATUS, v);
      chk_val({14'h0000, v[2:1]}, 16'h0000);
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      pd_sample = 8'h10;
      miscompares = 0;
      total_checks = 0;
      cycles = 0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      t_addr();
      t_reset_vals();
      t_pointer();
      // two samples of 0x10, gain shift 1: raw 64
      t_measure(9'h005, 14'd59);
      t_measure(9'h00a, 14'd54);
      t_measure(9'h1fb, 14'd69);
      t_measure(9'h0ff, 14'd0);
      t_power();
      give_verdict();
   end
endmodule
